// ---- rtl/acpc_map.svh ----
`ifndef ACPC_MAP_SVH
`define ACPC_MAP_SVH

// conversion time in ns, typical
`define ACPC_CONV_TIME_NS    500
// clock period in ns
`define ACPC_CLK_PERIOD_NS   10
// conversion length in cycles
`define ACPC_CONV_CYCLES     (`ACPC_CONV_TIME_NS / `ACPC_CLK_PERIOD_NS)
// channel count and code width
`define ACPC_NUM_CHANNELS    8
`define ACPC_CODE_WIDTH      16
// reset value of the selected channel
`define ACPC_CHAN_RESET      3'h0
// reset value of the span code
`define ACPC_SPAN_RESET      3'h7
// bit of the span code that marks a bipolar range
`define ACPC_SPAN_BIPOLAR_BIT 1

`endif

// ---- rtl/acpc_pkg.sv ----
package acpc_pkg;

    // controller states
    typedef enum logic [1:0]
    {
        ACPC_IDLE,
        ACPC_CONVERT,
        ACPC_POWERED_DOWN
    } acpc_state_e;

    // one conversion request as latched at its start
    typedef struct packed
    {
        logic [2:0] channel;
        logic [2:0] span;
    } acpc_request_s;

    // one finished result
    typedef struct packed
    {
        logic [15:0] code;
        logic [2:0]  channel;
        logic [2:0]  span;
    } acpc_result_s;

endpackage : acpc_pkg

// ---- rtl/acpc_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

// two-flop synchroniser with a registered rising-edge detect
module acpc_sync
(
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic async_i,
    output logic      level_o,
    output logic      rise_o
);

    // state of the synchroniser
    typedef struct packed
    {
        logic meta;
        logic level;
        logic prev;
    } acpc_sync_s;

    acpc_sync_s st;      // registered state
    acpc_sync_s next_st; // next state

    ////////////////////////////////////////////////////////////////////////////
    // next state: meta only feeds level
    always_comb
    begin
        next_st       = st;
        next_st.meta  = async_i;
        next_st.level = st.meta;
        next_st.prev  = st.level;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign level_o = st.level;
    assign rise_o  = st.level & ~st.prev;

endmodule : acpc_sync

`default_nettype wire

// ---- rtl/acpc_ctrl.sv ----
`include "acpc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module acpc_ctrl
#(
    parameter int CONV_CYCLES = `ACPC_CONV_CYCLES, // cycles per conversion
    parameter int CODE_WIDTH  = `ACPC_CODE_WIDTH   // result width
)
(
    input  wire logic                         core_clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         conversion_start_i,  // pin
    input  wire logic                         power_down_input_i,  // pin
    input  wire logic                         lvds_select_i,       // strap
    input  wire logic                         serial_cs_n_i,       // unused by start
    input  wire logic [2:0]                   channel_select_i,    // next channel
    input  wire logic [2:0]                   input_span_code_i,   // next span
    input  wire logic [CODE_WIDTH-1:0]        channel_positive_inputs_i [8],
    input  wire logic [CODE_WIDTH-1:0]        channel_negative_inputs_i [8],
    output logic                              busy_o,
    output logic                              sample_hold_o,
    output logic                              powered_down_o,
    output logic                              global_reset_o,
    output logic                              lvds_mode_o,
    output logic                              result_valid_o,
    output acpc_pkg::acpc_result_s            result_o
);

    localparam int CW = $clog2(CONV_CYCLES + 1); // counter width

    // whole block state
    typedef struct packed
    {
        acpc_pkg::acpc_state_e   state;
        logic [CW-1:0]           count;    // cycles left in conversion
        acpc_pkg::acpc_request_s req;      // latched channel and span
        logic                    pd_armed; // one pd pulse seen, no conversion yet
        logic                    greset;   // global reset pulse
        logic                    lvds;     // synchronised io standard
        logic                    valid;    // result strobe
        acpc_pkg::acpc_result_s  result;   // last result
    } acpc_ctrl_s;

    acpc_ctrl_s st;      // registered state
    acpc_ctrl_s next_st; // next state

    logic start_rise; // synchronised start edge
    logic pd_level;   // synchronised power-down level
    logic pd_rise;    // synchronised power-down edge
    logic lvds_level; // synchronised strap

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // start edge; chip select never gates it
    acpc_sync u_sync_start
    (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (conversion_start_i),
        .level_o    (),
        .rise_o     (start_rise)
    );

    // power-down level and edge
    acpc_sync u_sync_pd
    (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (power_down_input_i),
        .level_o    (pd_level),
        .rise_o     (pd_rise)
    );

    // io standard strap
    acpc_sync u_sync_lvds
    (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .async_i    (lvds_select_i),
        .level_o    (lvds_level),
        .rise_o     ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // digitise selected differential pair in the span's format
    function automatic logic [CODE_WIDTH-1:0] convert
    (
        input logic [CODE_WIDTH-1:0] pos,
        input logic [CODE_WIDTH-1:0] neg,
        input logic [2:0]            span
    );
        logic [CODE_WIDTH-1:0] diff;
        diff = pos - neg;
        if (span[`ACPC_SPAN_BIPOLAR_BIT])
        begin
            // spans 7,6,3,2: signed, -1 is all ones
            convert = diff;
        end
        else
        begin
            // spans 5,4,1,0: straight binary, negative clamps to zero
            convert = (pos < neg) ? '0 : diff;
        end
    endfunction : convert

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        next_st        = st;
        next_st.valid  = 1'b0;
        next_st.greset = 1'b0;
        // io standard follows the synchronised strap; a one-shot capture
        // would latch the sync's reset value instead of the pin
        next_st.lvds   = lvds_level;
        // second pd pulse with no conversion between: global reset
        if (pd_rise)
        begin
            if (st.pd_armed)
            begin
                next_st.greset   = 1'b1;
                next_st.pd_armed = 1'b0;
            end
            else
            begin
                next_st.pd_armed = 1'b1;
            end
        end
        case (st.state)
            acpc_pkg::ACPC_IDLE:
            begin
                if (pd_level)
                begin
                    // powered down, start edges dropped
                    next_st.state = acpc_pkg::ACPC_POWERED_DOWN;
                end
                else if (start_rise)
                begin
                    // hold and start conversion of selected channel
                    next_st.state       = acpc_pkg::ACPC_CONVERT;
                    next_st.count       = CW'(CONV_CYCLES - 1);
                    next_st.req.channel = channel_select_i;
                    next_st.req.span    = input_span_code_i;
                    next_st.pd_armed    = 1'b0;
                end
            end
            acpc_pkg::ACPC_CONVERT:
            begin
                // counter times the conversion
                if (st.count == '0)
                begin
                    next_st.valid          = 1'b1;
                    next_st.result.channel = st.req.channel;
                    next_st.result.span    = st.req.span;
                    next_st.result.code    = convert(
                        channel_positive_inputs_i[st.req.channel],
                        channel_negative_inputs_i[st.req.channel],
                        st.req.span);
                    // pending power-down taken only after the end
                    next_st.state = pd_level ? acpc_pkg::ACPC_POWERED_DOWN
                                             : acpc_pkg::ACPC_IDLE;
                end
                else
                begin
                    next_st.count = st.count - CW'(1);
                end
            end
            acpc_pkg::ACPC_POWERED_DOWN:
            begin
                // leave once pd drops; edges meanwhile ignored
                if (!pd_level)
                begin
                    next_st.state = acpc_pkg::ACPC_IDLE;
                end
            end
            default:
            begin
                next_st.state = acpc_pkg::ACPC_IDLE;
            end
        endcase
        // global reset returns everything to power-on values except state, which goes to powered-down, not idle, and lvds, which follows the strap
        if (st.greset)
        begin
            next_st             = '0;
            next_st.state       = acpc_pkg::ACPC_POWERED_DOWN;
            next_st.req.channel = `ACPC_CHAN_RESET;
            next_st.req.span    = `ACPC_SPAN_RESET;
            next_st.lvds        = lvds_level; // strap is a pin, not state
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st             <= '0;
            st.state       <= acpc_pkg::ACPC_IDLE;
            st.req.channel <= `ACPC_CHAN_RESET;
            st.req.span    <= `ACPC_SPAN_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign busy_o         = (st.state == acpc_pkg::ACPC_CONVERT);
    assign sample_hold_o  = (st.state == acpc_pkg::ACPC_CONVERT);
    assign powered_down_o = (st.state == acpc_pkg::ACPC_POWERED_DOWN);
    assign global_reset_o = st.greset;
    assign lvds_mode_o    = st.lvds;
    assign result_valid_o = st.valid;
    assign result_o       = st.result;

endmodule : acpc_ctrl

`default_nettype wire

// ---- sim/acpc_ctrl_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
// port-level checks on the conversion controller
module acpc_ctrl_checker
#(
    parameter int CONV_CYCLES = 50
)
(
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    input  wire logic conversion_start_i,
    input  wire logic power_down_input_i,
    input  wire logic lvds_select_i,
    input  wire logic busy_o,
    input  wire logic sample_hold_o,
    input  wire logic powered_down_o,
    input  wire logic global_reset_o,
    input  wire logic lvds_mode_o,
    input  wire logic result_valid_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    int bcnt; // busy cycles so far
    int rcnt; // cycles since any reset, saturating
    // helper counters
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            bcnt <= 0;
            rcnt <= 0;
        end
        else
        begin
            bcnt <= busy_o ? bcnt + 1 : 0;
            rcnt <= global_reset_o ? 0 : ((rcnt < 7) ? rcnt + 1 : rcnt);
        end
    end
    // end of a conversion
    sequence s_end;
        !busy_o && result_valid_o;
    endsequence
    AST_SH: assert property (sample_hold_o == busy_o)
        else $error("hold differs from busy");
    AST_START: assert property ($rose(busy_o) |-> $past(conversion_start_i))
        else $error("busy rose without start");
    AST_NOPD: assert property ($rose(busy_o) |-> !$past(powered_down_o))
        else $error("start taken while powered down");
    AST_PD_IDLE: assert property (powered_down_o |-> !busy_o)
        else $error("busy while powered down");
    AST_LEN: assert property ($fell(busy_o) |-> s_end ##0 (bcnt == CONV_CYCLES))
        else $error("wrong conversion length");
    AST_VALID_END: assert property (result_valid_o |-> $fell(busy_o))
        else $error("result outside conversion end");
    AST_PD_WAIT: assert property ($fell(busy_o) && $past(power_down_input_i, 2)
        && $past(power_down_input_i, 3) |-> powered_down_o)
        else $error("deferred power-down missing");
    AST_GRST: assert property (global_reset_o |=> powered_down_o)
        else $error("global reset not followed by power-down");
    AST_LVDS: assert property (rcnt == 7 |-> lvds_mode_o == lvds_select_i)
        else $error("io mode differs from strap");
endmodule : acpc_ctrl_checker
bind acpc_ctrl acpc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .conversion_start_i(conversion_start_i),
    .power_down_input_i(power_down_input_i), .lvds_select_i(lvds_select_i), .busy_o(busy_o),
    .sample_hold_o(sample_hold_o), .powered_down_o(powered_down_o),
    .global_reset_o(global_reset_o), .lvds_mode_o(lvds_mode_o),
    .result_valid_o(result_valid_o));
`default_nettype wire

// ---- sim/acpc_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// host side: drives the start and power-down pins
module acpc_host
(
    input  wire logic core_clk_i,
    output logic      conversion_start_o,
    output logic      power_down_o
);
    initial
    begin
        conversion_start_o = 1'b0;
        power_down_o       = 1'b0;
    end
    // start pulse, high four cycles
    task automatic start_pulse();
        @(posedge core_clk_i) #1 conversion_start_o = 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1 conversion_start_o = 1'b0;
    endtask : start_pulse
    // two rises with no conversion between ask for a full reset
    task automatic set_pd(input logic v);
        @(posedge core_clk_i) #1 power_down_o = v;
    endtask : set_pd
endmodule : acpc_host
`default_nettype wire

// ---- sim/adc_conversion_power_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_power_control_bench;
    localparam int CONV = 5; // shortened conversion
    logic core_clk_i, nrst_i, lvds_select_i, serial_cs_n_i, conversion_start_i;
    logic power_down_input_i, busy_o, sample_hold_o, powered_down_o, global_reset_o;
    logic lvds_mode_o, result_valid_o;
    logic [2:0] channel_select_i, input_span_code_i;
    logic [15:0] pos [8];
    logic [15:0] neg [8];
    acpc_pkg::acpc_result_s result_o;
    acpc_pkg::acpc_result_s exp_q [$]; // expected results
    int n_errors, samples_checked, n_grst, cycles;
    acpc_ctrl #(.CONV_CYCLES(CONV)) i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .conversion_start_i(conversion_start_i), .power_down_input_i(power_down_input_i),
        .lvds_select_i(lvds_select_i), .serial_cs_n_i(serial_cs_n_i),
        .channel_select_i(channel_select_i), .input_span_code_i(input_span_code_i),
        .channel_positive_inputs_i(pos), .channel_negative_inputs_i(neg), .busy_o(busy_o),
        .sample_hold_o(sample_hold_o), .powered_down_o(powered_down_o),
        .global_reset_o(global_reset_o), .lvds_mode_o(lvds_mode_o),
        .result_valid_o(result_valid_o), .result_o(result_o));
    acpc_host i_host (.core_clk_i(core_clk_i), .conversion_start_o(conversion_start_i),
        .power_down_o(power_down_input_i));
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task automatic fail(input string msg);
        n_errors++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask : fail
    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok) fail(msg);
    endtask : chk
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    // result monitor against the model queue, plus timeout; settled values
    always @(negedge core_clk_i)
    begin
        cycles++;
        if (global_reset_o === 1'b1) n_grst++;
        if (result_valid_o === 1'b1)
        begin
            samples_checked++;
            if (exp_q.size() == 0) fail("result not expected");
            else if (result_o !== exp_q.pop_front()) fail("result mismatch");
        end
        if (cycles == 3000)
        begin
            fail("timeout");
            report_and_stop();
        end
    end
    // one conversion; d is positive minus negative on the chosen channel
    task automatic conv(input logic [2:0] sp, input bit taken, input bit pd_mid, input int d);
        acpc_pkg::acpc_result_s e;
        int p;
        int n;
        @(posedge core_clk_i) #1;
        p = $urandom_range(16'hffff);
        n = (p - d) & 16'hffff;
        e.channel = 3'($urandom_range(7));
        e.span = sp;
        e.code = sp[1] ? 16'(p - n) : ((p > n) ? 16'(p - n) : 16'h0000);
        foreach (pos[k])
        begin
            pos[k] = 16'($urandom);
            neg[k] = 16'($urandom);
        end
        pos[e.channel] = 16'(p);
        neg[e.channel] = 16'(n);
        channel_select_i = e.channel;
        input_span_code_i = sp;
        serial_cs_n_i = 1'($urandom);
        if (taken) exp_q.push_back(e);
        fork
            i_host.start_pulse();
            if (pd_mid)
            begin
                repeat (3) @(posedge core_clk_i);
                i_host.set_pd(1'b1);
            end
        join
        repeat (CONV + 6) @(posedge core_clk_i);
        #1 chk(exp_q.size() == 0, "result missing");
    endtask : conv
    initial
    begin
        {nrst_i, serial_cs_n_i, channel_select_i, input_span_code_i} = '0;
        foreach (pos[k])
        begin
            pos[k] = '0;
            neg[k] = '0;
        end
        void'($urandom(32'hdd0d));
        lvds_select_i = 1'($urandom);
        repeat (2) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1 chk(lvds_mode_o === lvds_select_i, "strap not captured");
        for (int i = 0; i < 24; i++) conv(3'(i), 1, 0, i < 8 ? -1 : (i < 16 ? 1 : $urandom));
        i_host.set_pd(1'b1);
        repeat (4) @(posedge core_clk_i);
        #1 chk(powered_down_o === 1'b1, "not powered down");
        conv(3'h7, 0, 0, 5);
        i_host.set_pd(1'b0);
        repeat (5) @(posedge core_clk_i);
        conv(3'h2, 1, 1, 9);
        chk(powered_down_o === 1'b1, "no deferred power-down");
        i_host.set_pd(1'b0);
        repeat (5) @(posedge core_clk_i);
        i_host.set_pd(1'b1);
        repeat (5) @(posedge core_clk_i);
        #1 chk(n_grst == 1 && powered_down_o === 1'b1 && result_o === '0, "no reset");
        i_host.set_pd(1'b0);
        repeat (5) @(posedge core_clk_i);
        conv(3'h5, 1, 0, 3);
        // second reset in mid-run, strap flipped while reset is low
        #1 nrst_i = 1'b0;
        lvds_select_i = ~lvds_select_i;
        repeat (2) @(posedge core_clk_i);
        #1 chk(busy_o === 1'b0 && powered_down_o === 1'b0, "outputs not reset");
        nrst_i = 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1 chk(lvds_mode_o === lvds_select_i, "strap not recaptured");
        conv(3'h6, 1, 0, -300);
        report_and_stop();
    end
endmodule : adc_conversion_power_control_bench
`default_nettype wire
